// ### core/adcsp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module adcsp_ctrl
(
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  adcsp_if.ctl               link,
  input  wire logic          req_valid,
  output logic               req_ready,
  input  wire logic          req_read,
  input  wire logic          req_hw_reset,
  input  wire logic [7:0]    req_addr,
  input  wire logic [15:0]   req_data,
  output logic               rsp_valid,
  output logic [15:0]        rsp_data
);
  typedef enum logic [2:0]
  {
    ADCSP_C_IDLE = 3'b000,
    ADCSP_C_RST  = 3'b001,
    ADCSP_C_WAIT = 3'b010,
    ADCSP_C_LOW  = 3'b011,
    ADCSP_C_HIGH = 3'b100,
    ADCSP_C_END  = 3'b101
  } adcsp_cstate_t;

  adcsp_cstate_t  state;
  adcsp_cstate_t  next_state;
  logic [15:0]    div;
  logic [15:0]    next_div;
  logic [4:0]     bitn;
  logic [4:0]     next_bitn;
  logic [23:0]    sh;
  logic [23:0]    next_sh;
  logic [15:0]    rx;
  logic [15:0]    next_rx;
  logic           rd;
  logic           next_rd;
  logic           sdo_s1;
  logic           sdo_s2;
  logic           next_rsp_valid;
  logic           oe_s1;
  logic           oe_s2;
  logic           next_sclk;
  logic           next_cs_b;
  logic           next_sdi;
  logic           next_rst_pin;

  // Each sclk phase lasts CTRL_DIV_HALF+1 cycles: 10 MHz, under 15 MHz [R06]
  always_comb
  begin
    next_state     = state;
    next_div       = div + 16'h0001;
    next_bitn      = bitn;
    next_sh        = sh;
    next_rx        = rx;
    next_rd        = rd;
    next_rsp_valid = 1'b0;
    unique case (state)
      ADCSP_C_IDLE:
      begin
        next_div = 16'h0000;
        if (req_valid && req_hw_reset)
          next_state = ADCSP_C_RST;                   // [R07] [R12]
        else if (req_valid)
        begin
          next_sh    = {req_addr, req_data};          // [R05] [R21]
          next_rd    = req_read;
          next_bitn  = 5'h00;
          next_state = ADCSP_C_LOW;
        end
      end
      ADCSP_C_RST:
        if (div == {12'h000, adcsp_pkg::RST_PULSE_C4})
        begin
          next_div   = 16'h0000;
          next_state = ADCSP_C_WAIT;                  // [R10]
        end
      ADCSP_C_WAIT:
        if (div == {12'h000, adcsp_pkg::RST_WAIT_C4})
          next_state = ADCSP_C_IDLE;                  // [R11]
      ADCSP_C_LOW:
        if (div == adcsp_pkg::CTRL_DIV_HALF)
        begin
          next_div   = 16'h0000;
          next_state = ADCSP_C_HIGH;
          // Rising edge: device samples our bit, we sample its output
          // A released output line reads low, as with a pull-down
          if (bitn > adcsp_pkg::CNT_ADDR_DONE)
            next_rx = {rx[14:0], sdo_s2 && oe_s2};    // [R17]
        end
      ADCSP_C_HIGH:
        if (div == adcsp_pkg::CTRL_DIV_HALF)
        begin
          next_div  = 16'h0000;
          next_sh   = {sh[22:0], 1'b0};
          next_bitn = bitn + 5'h01;
          next_state = (bitn == adcsp_pkg::CNT_LAST) ? ADCSP_C_END
                                                     : ADCSP_C_LOW;
        end
      ADCSP_C_END:
        if (div == adcsp_pkg::CTRL_DIV_HALF)
        begin
          next_rsp_valid = rd;                        // [R16]
          next_state     = ADCSP_C_IDLE;
        end
      default:
        next_state = ADCSP_C_IDLE;
    endcase
    next_sclk    = (next_state == ADCSP_C_HIGH);
    next_cs_b    = !(next_state == ADCSP_C_LOW
                     || next_state == ADCSP_C_HIGH
                     || next_state == ADCSP_C_END);
    next_sdi     = next_sh[23];
    next_rst_pin = (next_state == ADCSP_C_RST);       // [R10]
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state     <= ADCSP_C_IDLE;
      div       <= 16'h0000;
      bitn      <= 5'h00;
      sh        <= 24'h00_0000;
      rx        <= 16'h0000;
      rd        <= 1'b0;
      rsp_valid <= 1'b0;
      sdo_s1    <= 1'b0;
      sdo_s2    <= 1'b0;
      oe_s1     <= 1'b0;
      oe_s2     <= 1'b0;
      link.sclk           <= 1'b0;
      link.cs_b           <= 1'b1;
      link.serial_data_in <= 1'b0;
      link.reset_pin      <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      div       <= next_div;
      bitn      <= next_bitn;
      sh        <= next_sh;
      rx        <= next_rx;
      rd        <= next_rd;
      rsp_valid <= next_rsp_valid;
      sdo_s1    <= link.serial_data_out;
      sdo_s2    <= sdo_s1;
      oe_s1     <= link.serial_data_out_oe;
      oe_s2     <= oe_s1;
      link.sclk           <= next_sclk;
      link.cs_b           <= next_cs_b;
      link.serial_data_in <= next_sdi;
      link.reset_pin      <= next_rst_pin;
    end
  end

  assign req_ready = (state == ADCSP_C_IDLE);
  assign rsp_data  = rx;
endmodule
`default_nettype wire

// ### core/adcsp_device.sv
// Notes on behaviour
// R01: Shift a bit per rising clock while selected
// R02: Every 24th edge writes the addressed register
// R03: Partial trailing word is dropped
// R04: Many words may share one select period
// R05: Eight address bits, then sixteen data bits
// R06: Works at any clock rate, duty
// R07: Controller resets registers after power-up; here the controller pulses the reset pin only on a req_hw_reset request
// R08: Software reset loads defaults, self-clears
// R09: Software reset is address 0 bit 0
// R10: Reset pin pulse at least 50 ns
// R11: Wait 100 ns after reset before select
// R12: Serial mode uses reset pulse, not tie
// R13: Serial output idle after any reset
// R14: Readout blocks writes except address 1
// R15: Address 1 cannot be read back
// R16: Addressed register shifted out in readout
// R17: Controller samples readback on rising edge
// R18: Clearing readout re-enables writes, floats output
// R19: Default conversion and output interface settings
// R20: Default readout off, modes off, gain 0
// R21: MSB first; select high clears counter
// R22: Readback MSB driven after eighth address bit
`timescale 1ns/1ps
`default_nettype none
module adcsp_device
(
  input  wire logic          rst_b,
  adcsp_if.dev               link,
  output logic               readout_en,
  output logic [15:0]        reg_rd_data,
  input  wire logic [7:0]    reg_rd_addr
);
  typedef enum logic [0:0]
  {
    ADCSP_IDLE  = 1'b0,
    ADCSP_SHIFT = 1'b1
  } adcsp_state_t;

  // The whole device runs on the link clock; the reset pin is folded in
  // asynchronously because the serial clock may be stopped during reset.
  adcsp_state_t  state;
  adcsp_state_t  next_state;
  logic [4:0]    cnt;
  logic [4:0]    next_cnt;
  logic [22:0]   shreg;
  logic [22:0]   next_shreg;
  logic [15:0]   regs [adcsp_pkg::NUM_REGS];
  logic [15:0]   next_regs [adcsp_pkg::NUM_REGS];
  logic [15:0]   rb_shift;
  logic [15:0]   next_rb_shift;
  logic          rb_active;
  logic          next_rb_active;
  logic          wr_en;
  logic [7:0]    wr_addr;
  logic [15:0]   wr_data;
  logic          soft_rst;
  logic [7:0]    rb_addr;

  // Address 1 holds the readout bit, so it stays writable in readout mode
  // but is never shifted back out.
  function automatic logic adcsp_is_readout_addr(input logic [7:0] addr);
    return addr == adcsp_pkg::ADDR_READOUT;
  endfunction

  // Pin reset or bench reset clears at once; the serial clock may be
  // stopped, so neither can wait for an edge.
  wire logic hard_clr = link.reset_pin || !rst_b;

  assign readout_en  = regs[adcsp_pkg::ADDR_READOUT][adcsp_pkg::READOUT_BIT];
  assign reg_rd_data = regs[reg_rd_addr];
  assign rb_addr     = {shreg[6:0], link.serial_data_in};

  always_comb
  begin
    next_state     = state;
    next_cnt       = cnt;
    next_shreg     = {shreg[21:0], link.serial_data_in}; // [R01] [R21] [R06]
    wr_en          = 1'b0;
    wr_addr        = shreg[22:15];                    // [R05]
    wr_data        = {shreg[14:0], link.serial_data_in};
    unique case (state)
      ADCSP_IDLE:
      begin
        next_cnt   = 5'h01;
        next_state = ADCSP_SHIFT;
      end
      ADCSP_SHIFT:
      begin
        if (cnt == adcsp_pkg::CNT_LAST)
        begin
          next_cnt = 5'h00;                           // [R04]
          wr_en    = 1'b1;                            // [R02]
        end
        else
        begin
          next_cnt = cnt + 5'h01;
        end
      end
    endcase
    if (state == ADCSP_IDLE && cnt == 5'h00)
    begin
      next_cnt = 5'h01;
    end
    // Blocked writes still complete the word count [R14]
    if (readout_en && !adcsp_is_readout_addr(wr_addr))
    begin
      wr_en = 1'b0;
    end
  end

  // Readback group: the shifter is loaded once the address byte is in
  // and released at the end of the word, blocked or not.
  always_comb
  begin
    next_rb_shift  = {rb_shift[14:0], 1'b0};
    next_rb_active = rb_active;
    if (readout_en && state == ADCSP_SHIFT
        && cnt == adcsp_pkg::CNT_ADDR_DONE)           // [R22]
    begin
      next_rb_active = !adcsp_is_readout_addr(rb_addr); // [R15]
      next_rb_shift  = regs[rb_addr];                 // [R16]
    end
    else if (state == ADCSP_SHIFT && cnt == adcsp_pkg::CNT_LAST)
    begin
      next_rb_active = 1'b0;
    end
  end

  // Bit counter: cleared while select is high, so any leftover bits
  // short of a word never reach the write strobe. [R03] [R21]
  always_ff @(posedge link.sclk or posedge link.cs_b or posedge hard_clr)
  begin
    if (hard_clr || link.cs_b)
    begin
      state     <= ADCSP_IDLE;
      cnt       <= 5'h00;
      rb_active <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      rb_active <= next_rb_active;
    end
  end

  always_ff @(posedge link.sclk)
  begin
    shreg <= next_shreg;
  end

  // Cleared with the pins so the output shows a defined level after reset
  always_ff @(posedge link.sclk or posedge hard_clr)
  begin
    if (hard_clr)
    begin
      rb_shift <= adcsp_pkg::REG_DEFAULT;             // [R13]
    end
    else
    begin
      rb_shift <= next_rb_shift;
    end
  end

  assign soft_rst = wr_en && wr_addr == adcsp_pkg::ADDR_RESET
                    && wr_data[adcsp_pkg::RESET_BIT];

  // Software reset rewrites every register to its default, including the
  // reset bit itself, so the bit never reads back as one. [R08] [R09]
  always_comb
  begin
    for (int i = 0; i < adcsp_pkg::NUM_REGS; i++)
    begin
      next_regs[i] = regs[i];
    end
    if (soft_rst)
    begin
      for (int i = 0; i < adcsp_pkg::NUM_REGS; i++)
      begin
        next_regs[i] = adcsp_pkg::REG_DEFAULT;
      end
    end
    else if (wr_en)
    begin
      next_regs[wr_addr] = wr_data;                   // [R02] [R14] [R18]
    end
  end

  // Pin reset clears the whole array at once, even with the serial
  // clock stopped.
  always_ff @(posedge link.sclk or posedge hard_clr)
  begin
    if (hard_clr)
    begin
      for (int i = 0; i < adcsp_pkg::NUM_REGS; i++)
      begin
        regs[i] <= adcsp_pkg::REG_DEFAULT;            // [R19] [R20]
      end
    end
    else
    begin
      regs <= next_regs;
    end
  end

  // Driven only while a readback word is in flight. [R13] [R18]
  assign link.serial_data_out_oe = readout_en && rb_active;
  assign link.serial_data_out    = rb_shift[15];
endmodule
`default_nettype wire

// ### core/adcsp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adcsp_if;
  logic sclk;
  logic cs_b;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_oe;
  logic reset_pin;
  modport dev
  (
    input  sclk,
    input  cs_b,
    input  serial_data_in,
    input  reset_pin,
    output serial_data_out,
    output serial_data_out_oe
  );
  modport ctl
  (
    output sclk,
    output cs_b,
    output serial_data_in,
    output reset_pin,
    input  serial_data_out,
    input  serial_data_out_oe
  );
endinterface
`default_nettype wire

// ### core/adcsp_pkg.sv
package adcsp_pkg;
  localparam int           WORD_BITS     = 24;
  localparam int           ADDR_BITS     = 8;
  localparam int           DATA_BITS     = 16;
  localparam logic [4:0]   CNT_LAST      = 5'h17;
  localparam logic [4:0]   CNT_ADDR_DONE = 5'h07;
  localparam logic [7:0]   ADDR_RESET    = 8'h00;
  localparam logic [7:0]   ADDR_READOUT  = 8'h01;
  localparam int           RESET_BIT     = 0;
  localparam int           READOUT_BIT   = 0;
  localparam int           NUM_REGS      = 256;
  localparam logic [15:0]  REG_DEFAULT   = 16'h0000;
  localparam logic [15:0]  CTRL_DIV_HALF = 16'h0004;
  localparam int           CLK_HZ        = 100_000_000;
  localparam int           RST_PULSE_NS  = 50;
  localparam int           RST_WAIT_NS   = 100;
  localparam int           RST_PULSE_CYC =
    (RST_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int           RST_WAIT_CYC  =
    (RST_WAIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0]   RST_PULSE_C4  = 4'(RST_PULSE_CYC);
  localparam logic [3:0]   RST_WAIT_C4   = 4'(RST_WAIT_CYC);
endpackage

// ### test/adcsp_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adcsp_assertions
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic serial_data_in,
  input wire logic serial_data_out_oe,
  input wire logic reset_pin
);
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  always_comb
  begin
    next_cnt = (cnt == 5'h17) ? 5'h00 : cnt + 5'h01;
  end
  // Select high ends the frame while the serial clock stands still
  always_ff @(posedge sclk or posedge cs_b)
  begin
    if (cs_b)
      cnt <= 5'h00;
    else
      cnt <= next_cnt;
  end
  a_idle_after_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !$past(rst_b) |-> cs_b && !sclk && !reset_pin) else $error("link not idle");
  a_reset_pulse_long: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(reset_pin) |-> reset_pin[*5]) else $error("reset pulse short");
  a_select_wait: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(reset_pin) |-> cs_b[*8] ##1 cs_b[*2]) else $error("select too soon");
  a_sclk_in_frame: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(sclk) |-> !cs_b) else $error("clock edge outside frame");
  a_select_setup: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(cs_b) |-> !sclk[*3]) else $error("select setup short");
  a_data_held: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(sclk) |-> $stable(serial_data_in)) else $error("data moved at edge");
  a_oe_in_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reset_pin |-> !serial_data_out_oe) else $error("output driven in reset");
  a_oe_after_addr: assert property (@(posedge sclk)
    disable iff (reset_pin || !rst_b)
    $rose(serial_data_out_oe) |-> cnt == 5'h08) else $error("readback start");
  a_readback_span: assert property (@(posedge sclk)
    disable iff (reset_pin || !rst_b)
    $rose(serial_data_out_oe) |-> serial_data_out_oe[*8] ##1
    serial_data_out_oe[*8] ##1 !serial_data_out_oe)
    else $error("readback cut short");
endmodule
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_b;
  logic        req_valid;
  logic        req_ready;
  logic        req_read;
  logic        req_hw_reset;
  logic [7:0]  req_addr;
  logic [15:0] req_data;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic [15:0] got;
  logic        ro_en;
  logic        ro_en2;
  logic [7:0]  rd_addr;
  logic [15:0] rd_data;
  logic [7:0]  rd_addr2;
  logic [15:0] rd_data2;
  int          n_errors = 0;
  int          checked = 0;
  adcsp_if link();
  adcsp_if link2();
  always #5 sys_clk = ~sys_clk;
  adcsp_ctrl i_adcsp_ctrl
  (
    .sys_clk(sys_clk), .rst_b(rst_b), .link(link), .req_valid(req_valid),
    .req_ready(req_ready), .req_read(req_read), .req_hw_reset(req_hw_reset),
    .req_addr(req_addr), .req_data(req_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data)
  );
  adcsp_device i_adcsp_device
  (
    .rst_b(rst_b), .link(link), .readout_en(ro_en),
    .reg_rd_data(rd_data), .reg_rd_addr(rd_addr)
  );
  // Second device faces the bench directly to send ragged frames
  adcsp_device i_adcsp_device_2
  (
    .rst_b(rst_b), .link(link2), .readout_en(ro_en2),
    .reg_rd_data(rd_data2), .reg_rd_addr(rd_addr2)
  );
  adcsp_assertions i_adcsp_assertions
  (
    .sys_clk(sys_clk), .rst_b(rst_b), .sclk(link.sclk), .cs_b(link.cs_b),
    .serial_data_in(link.serial_data_in), .reset_pin(link.reset_pin),
    .serial_data_out_oe(link.serial_data_out_oe)
  );
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic req(input logic rd, input logic hw, input logic [7:0] a,
                     input logic [15:0] d);
    int i;
    while (!req_ready)
      @(posedge sys_clk) #1;
    {req_read, req_hw_reset, req_addr, req_data} = {rd, hw, a, d};
    req_valid = 1'b1;
    @(posedge sys_clk) #1;
    req_valid = 1'b0;
    i = 0;
    // Ready and the read answer return in the same cycle
    while (!req_ready && i < 400)
    begin
      @(posedge sys_clk) #1;
      i++;
    end
    if (i >= 400 || rsp_valid !== rd)
    begin
      n_errors++;
      $display("[FAIL] %0t transfer hung or answer missing", $time);
    end
    got = rsp_data;
  endtask
  task automatic peek(input logic [7:0] a, input logic [15:0] e);
    rd_addr = a;
    @(posedge sys_clk) #1;
    chk(rd_data, e);
  endtask
  task automatic frame2(input logic [57:0] v);
    link2.cs_b = 1'b0;
    for (int i = 57; i >= 0; i--)
    begin
      link2.serial_data_in = v[i];
      #32 link2.sclk = 1'b1;
      #32 link2.sclk = 1'b0;
    end
    link2.cs_b = 1'b1;
    link2.serial_data_in = ~v[0];
  endtask
  initial
  begin
    #200000;
    n_errors++;
    stop_test;
  end
  initial
  begin
    {rst_b, req_valid, req_read, req_hw_reset} = 4'h0;
    {req_addr, req_data, rd_addr, rd_addr2, got} = 56'h0;
    {link2.sclk, link2.cs_b, link2.serial_data_in, link2.reset_pin} = 4'h4;
    repeat (8) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    @(posedge sys_clk) #1;
    peek(8'h05, adcsp_pkg::REG_DEFAULT);
    chk(16'(ro_en), 16'h0000);
    chk(16'(link.serial_data_out_oe), 16'h0000);
    $display("test defaults done");
    req(1'b0, 1'b0, 8'h05, 16'hA5C3);
    peek(8'h05, 16'hA5C3);
    $display("test write done");
    req(1'b0, 1'b0, adcsp_pkg::ADDR_READOUT, 16'h0001);
    chk(16'(ro_en), 16'h0001);
    req(1'b0, 1'b0, 8'h05, 16'h0000);
    peek(8'h05, 16'hA5C3);
    req(1'b1, 1'b0, 8'h05, 16'h0000);
    chk(got, 16'hA5C3);
    req(1'b1, 1'b0, adcsp_pkg::ADDR_READOUT, 16'h0001);
    chk(got, 16'h0000);
    chk(16'(ro_en), 16'h0001);
    req(1'b0, 1'b0, adcsp_pkg::ADDR_READOUT, 16'h0000);
    chk(16'(ro_en), 16'h0000);
    chk(16'(link.serial_data_out_oe), 16'h0000);
    req(1'b0, 1'b0, 8'h05, 16'h3C5A);
    peek(8'h05, 16'h3C5A);
    $display("test readout done");
    req(1'b0, 1'b0, adcsp_pkg::ADDR_RESET, 16'h0001);
    peek(8'h05, 16'h0000);
    peek(adcsp_pkg::ADDR_RESET, 16'h0000);
    $display("test soft reset done");
    req(1'b0, 1'b0, 8'h07, 16'hFFFF);
    req(1'b0, 1'b1, 8'h00, 16'h0000);
    peek(8'h07, 16'h0000);
    $display("test hard reset done");
    #7;
    frame2({8'h03, 16'h1234, 8'h04, 16'h5678, 10'h3FF});
    rd_addr2 = 8'h03;
    #1 chk(rd_data2, 16'h1234);
    rd_addr2 = 8'h04;
    #1 chk(rd_data2, 16'h5678);
    rd_addr2 = 8'hFF;
    #1 chk(rd_data2, 16'h0000);
    frame2({8'h06, 16'hBEEF, 8'h07, 16'hCAFE, 10'h000});
    rd_addr2 = 8'h07;
    #1 chk(rd_data2, 16'hCAFE);
    rd_addr2 = 8'h06;
    #1 chk(rd_data2, 16'hBEEF);
    chk(16'(ro_en2), 16'h0000);
    $display("test ragged frame done");
    stop_test;
  end
endmodule
`default_nettype wire
